// ===== pkg/fsq_pkg.sv
package fsq_pkg;
  // Instruction cycle phases, one system clock each
  typedef enum logic [1:0]
  {
    FSQ_PH_FETCH = 2'h0,
    FSQ_PH_DEC   = 2'h1,
    FSQ_PH_EXEC  = 2'h2,
    FSQ_PH_WB    = 2'h3
  } fsq_phase_t;
  // Program flow request presented by the decoder during execution
  typedef enum logic [2:0]
  {
    FSQ_OP_SEQ    = 3'h0,
    FSQ_OP_JUMP   = 3'h1,
    FSQ_OP_CALL   = 3'h2,
    FSQ_OP_RET    = 3'h3,
    FSQ_OP_INTERRUPT_RETURN   = 3'h4,
    FSQ_OP_SKIP   = 3'h5,
    FSQ_OP_PCLWR  = 3'h6
  } fsq_op_t;
endpackage

// ===== pkg/fsq_regs.svh
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH
// Phase count per instruction cycle and its last index
`define FSQ_PHASES       4
`define FSQ_PHASE_LAST   2'h3
// Program counter layout: low byte, high part, page size
`define FSQ_PCL_W        8
`define FSQ_PCH_W        5
`define FSQ_PAGE_SIZE    256
// Return stack depth and reset vector
`define FSQ_STACK_DEPTH  12
`define FSQ_RESET_VECTOR 15'h0000
`define FSQ_IRQ_VECTOR   15'h0004
`endif

// ===== rtl/fsq_fetch_seq.sv
`timescale 1ns/1ns
`include "fsq_regs.svh"
module fsq_fetch_seq #(
  parameter int BANK_BITS = 2,
  parameter int DEPTH     = `FSQ_STACK_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [15:0]           instrData,
  input  wire fsq_pkg::fsq_op_t      flowOp,
  input  wire logic                  skipTaken,
  input  wire logic [12:0]           branchTarget,
  input  wire logic [7:0]            pcLowWrData,
  input  wire logic [BANK_BITS-1:0]  bankPointer,
  input  wire logic                  irqPending,
  output logic [12+BANK_BITS:0]      fetchAddr,
  output logic                       fetchStrobe,
  output logic [15:0]                execInstr,
  output logic                       execValid,
  output logic [1:0]                 cyclePhases,
  output logic                       cycleStart,
  output logic [7:0]                 pcLowByte,
  output logic                       irqAck,
  output logic                       stackFull
);
  localparam int PCW = 13 + BANK_BITS;
  localparam int SPW = 4;

  initial
  begin
    // The bank field is concatenated into the PC, so it cannot be empty
    if (BANK_BITS < 1 || BANK_BITS > 2)
      $error("fsq_fetch_seq: BANK_BITS must be 1 to 2");
    // The fill level must be able to count up to DEPTH itself
    if (DEPTH < 2 || DEPTH >= (1 << SPW))
      $error("fsq_fetch_seq: DEPTH out of range");
  end

  fsq_pkg::fsq_phase_t phase_q;
  logic [PCW-1:0]      pc_q;
  logic [PCW-1:0]      pc_d;
  logic [15:0]         prefetch_q;
  logic                dummy_q;
  logic [SPW-1:0]      sp_q;
  logic [SPW-1:0]      level_q;
  logic [PCW-1:0]      stackRd;
  logic                lastPhase;
  logic                doPush;
  logic                doPop;
  logic                takeIrq;
  logic                isBranch;
  logic [SPW-1:0]      spNext;
  logic [SPW-1:0]      spPrev;

  assign lastPhase = (phase_q == fsq_pkg::FSQ_PH_WB);
  // Interrupt only taken when a stack level is free
  assign takeIrq   = irqPending && !dummy_q && (level_q < DEPTH[SPW-1:0]);
  assign isBranch  = !dummy_q && (flowOp inside {fsq_pkg::FSQ_OP_JUMP, fsq_pkg::FSQ_OP_CALL,
                     fsq_pkg::FSQ_OP_RET, fsq_pkg::FSQ_OP_INTERRUPT_RETURN, fsq_pkg::FSQ_OP_PCLWR});
  assign doPush    = lastPhase && (takeIrq || (!dummy_q && flowOp == fsq_pkg::FSQ_OP_CALL));
  assign doPop     = lastPhase && !takeIrq && !dummy_q &&
                     (flowOp == fsq_pkg::FSQ_OP_RET || flowOp == fsq_pkg::FSQ_OP_INTERRUPT_RETURN);
  // Circular pointer arithmetic so overflow wraps onto the oldest entry
  assign spNext = (sp_q == SPW'(DEPTH - 1)) ? '0 : sp_q + 1'b1;
  assign spPrev = (sp_q == '0) ? SPW'(DEPTH - 1) : sp_q - 1'b1;

  // Four-phase sequencer, one phase per system clock
  always_ff @(posedge clk)
  begin
    if (rst)
      phase_q <= fsq_pkg::FSQ_PH_FETCH;
    else
      phase_q <= fsq_pkg::fsq_phase_t'(phase_q + 2'h1);
  end

  // Next program counter chosen at the end of each instruction cycle
  // A dummy cycle holds the PC so the new target is fetched again and executed
  always_comb
  begin
    pc_d = pc_q + 1'b1;
    if (takeIrq)
      pc_d = PCW'(`FSQ_IRQ_VECTOR);
    else if (dummy_q)
      pc_d = pc_q;
    else
    begin
      case (flowOp)
        fsq_pkg::FSQ_OP_JUMP,
        fsq_pkg::FSQ_OP_CALL:  pc_d = {bankPointer, branchTarget};
        fsq_pkg::FSQ_OP_RET,
        fsq_pkg::FSQ_OP_INTERRUPT_RETURN:  pc_d = stackRd;
        fsq_pkg::FSQ_OP_PCLWR: pc_d = {pc_q[PCW-1:8], pcLowWrData};
        // A taken skip steps over the following word
        fsq_pkg::FSQ_OP_SKIP:  pc_d = skipTaken ? pc_q + 2'h2 : pc_q + 1'b1;
        default:               pc_d = pc_q + 1'b1;
      endcase
    end
  end

  // Program counter; reset loads the reset vector
  always_ff @(posedge clk)
  begin
    if (rst)
      pc_q <= PCW'(`FSQ_RESET_VECTOR);
    else if (lastPhase)
      pc_q <= pc_d;
  end

  // Dummy cycle after branch, PC write or taken skip replaces the stale prefetch
  always_ff @(posedge clk)
  begin
    if (rst)
      dummy_q <= 1'b1;
    else if (lastPhase)
      dummy_q <= takeIrq || isBranch ||
                 (!dummy_q && flowOp == fsq_pkg::FSQ_OP_SKIP && skipTaken);
  end

  // Stack pointer and fill level; reset points at the top
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sp_q    <= '0;
      level_q <= '0;
    end
    else if (doPush)
    begin
      sp_q    <= spNext;
      if (level_q < DEPTH[SPW-1:0])
        level_q <= level_q + 1'b1;
    end
    else if (doPop)
    begin
      sp_q    <= spPrev;
      if (level_q != '0)
        level_q <= level_q - 1'b1;
    end
  end

  // Stack storage, hidden from software
  fsq_stack_mem #(.W(PCW), .DEPTH(DEPTH), .AW(SPW)) u_stack (
    .clk    (clk),
    .wrEn   (doPush),
    .wrAddr (sp_q),
    // A call saves the address after itself; an interrupt saves the discarded one
    .wrData (takeIrq ? pc_q : pc_q + 1'b1),
    .rdAddr (spPrev),
    .rdData (stackRd)
  );

  // Fetch request at phase one; data captured at the end of the phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fetchAddr   <= '0;
      fetchStrobe <= 1'b0;
      prefetch_q  <= '0;
    end
    else
    begin
      fetchStrobe <= lastPhase;
      if (lastPhase)
        fetchAddr <= pc_d;
      if (phase_q == fsq_pkg::FSQ_PH_FETCH)
        prefetch_q <= instrData;
    end
  end

  // Execution view and status outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      execInstr   <= '0;
      execValid   <= 1'b0;
      cyclePhases <= 2'h0;
      cycleStart  <= 1'b0;
      pcLowByte   <= 8'h00;
      irqAck      <= 1'b0;
      stackFull   <= 1'b0;
    end
    else
    begin
      cyclePhases <= phase_q + 2'h1;
      cycleStart  <= lastPhase;
      if (phase_q == fsq_pkg::FSQ_PH_FETCH)
      begin
        execInstr <= instrData;
        execValid <= !dummy_q;
      end
      pcLowByte <= pc_q[7:0];
      irqAck    <= doPush && takeIrq;
      stackFull <= (level_q == DEPTH[SPW-1:0]);
    end
  end

  // Helper: true in the write-back phase, the last phase of each instruction cycle
  sequence s_cycleEnd;
    phase_q == fsq_pkg::FSQ_PH_WB;
  endsequence

  a_phase_wrap: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd |=> phase_q == fsq_pkg::FSQ_PH_FETCH ##3 phase_q == fsq_pkg::FSQ_PH_WB)
    else $error("phase sequence broken");
  a_pc_seq: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd and !takeIrq and !dummy_q and !isBranch and
    !(flowOp == fsq_pkg::FSQ_OP_SKIP && skipTaken) |=> pc_q == $past(pc_q) + 1'b1)
    else $error("pc did not increment");
  a_pc_hold: assert property (@(posedge clk) disable iff (rst)
    !lastPhase |=> $stable(pc_q))
    else $error("pc changed mid cycle");
  a_branch_dummy: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd and isBranch |=> dummy_q [*4])
    else $error("branch without dummy cycle");
  a_skip_dummy: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd and !dummy_q and !takeIrq and flowOp == fsq_pkg::FSQ_OP_SKIP and skipTaken
    |=> dummy_q)
    else $error("taken skip without dummy");
  a_skip_none: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd and !dummy_q and !takeIrq and flowOp == fsq_pkg::FSQ_OP_SKIP and !skipTaken
    |=> !dummy_q)
    else $error("untaken skip inserted dummy");
  a_pclwr_page: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd and !dummy_q and !takeIrq and flowOp == fsq_pkg::FSQ_OP_PCLWR
    |=> pc_q[PCW-1:8] == $past(pc_q[PCW-1:8]) && pc_q[7:0] == $past(pcLowWrData))
    else $error("pc low write left page");
  a_irq_full: assert property (@(posedge clk) disable iff (rst)
    level_q == DEPTH[SPW-1:0] |-> !takeIrq)
    else $error("interrupt taken on full stack");
  a_reset_top: assert property (@(posedge clk)
    rst |=> sp_q == '0 && level_q == '0)
    else $error("stack not at top after reset");
  a_call_full: assert property (@(posedge clk) disable iff (rst)
    doPush && level_q == DEPTH[SPW-1:0] |=> level_q == DEPTH[SPW-1:0] && sp_q == $past(spNext))
    else $error("call on full stack mishandled");

  // Dummy cycles refetch the same address rather than advancing
  a_dummy_hold: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd and dummy_q |=> $stable(pc_q))
    else $error("pc moved in dummy cycle");
  a_skip_jump: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd and !dummy_q and !takeIrq and flowOp == fsq_pkg::FSQ_OP_SKIP and skipTaken
    |=> pc_q == $past(pc_q) + 2'h2)
    else $error("taken skip did not step over");
  a_irq_entry: assert property (@(posedge clk) disable iff (rst)
    s_cycleEnd and takeIrq |=> pc_q == PCW'(`FSQ_IRQ_VECTOR) && level_q == $past(level_q) + 1'b1)
    else $error("interrupt entry wrong");
  a_ret_pop: assert property (@(posedge clk) disable iff (rst)
    doPop |=> pc_q == $past(stackRd))
    else $error("return did not restore pc");

  // Output side: strobe shape, flags and acknowledge
  a_strobe_pulse: assert property (@(posedge clk) disable iff (rst)
    fetchStrobe |-> cyclePhases == 2'h0 ##1 !fetchStrobe)
    else $error("fetch strobe misplaced");
  a_full_flag: assert property (@(posedge clk) disable iff (rst)
    level_q == DEPTH[SPW-1:0] |=> stackFull)
    else $error("full flag missing");
  a_level_bound: assert property (@(posedge clk) disable iff (rst)
    level_q <= DEPTH[SPW-1:0])
    else $error("stack level above depth");
  a_irq_ack: assert property (@(posedge clk) disable iff (rst)
    doPush && takeIrq |=> irqAck)
    else $error("interrupt entry without acknowledge");
endmodule // fsq_fetch_seq

// ===== rtl/fsq_stack_mem.sv
`timescale 1ns/1ns
// Return stack storage; circular so an overflowing push overwrites the oldest entry
module fsq_stack_mem #(
  parameter int W     = 15,
  parameter int DEPTH = 12,
  parameter int AW    = 4
) (
  input  wire logic          clk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [W-1:0]  rdData
);
  logic [W-1:0] mem [DEPTH];

  initial
  begin
    if (DEPTH > (1 << AW))
      $error("fsq_stack_mem: DEPTH exceeds address range");
  end

  // Write port
  always_ff @(posedge clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end

  // Registered read
  always_ff @(posedge clk)
  begin
    rdData <= mem[rdAddr];
  end
endmodule // fsq_stack_mem

// ===== sim/fetch_sequencer_pc_stack_test.sv
`timescale 1ns/1ns
`include "fsq_regs.svh"
module fetch_sequencer_pc_stack_test;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [15:0]       instrData;
  fsq_pkg::fsq_op_t  flowOp = fsq_pkg::FSQ_OP_SEQ;
  logic              skipTaken = 1'b0;
  logic [12:0]       branchTarget = 13'h0000;
  logic [7:0]        pcLowWrData = 8'h00;
  logic [1:0]        bankPointer = 2'h0;
  logic              irqPending = 1'b0;
  logic [14:0]       fetchAddr;
  logic              fetchStrobe, execValid, cycleStart, irqAck, stackFull, ackSeen;
  logic [15:0]       execInstr;
  logic [1:0]        cyclePhases;
  logic [7:0]        pcLowByte;
  logic [14:0]       p, q;
  logic [14:0]       ret [13];
  int                n_mismatch = 0;
  int                checks = 0;
  // Clock at 100 MHz
  always #5 clk = ~clk;
  fsq_fetch_seq #(.BANK_BITS(2), .DEPTH(12)) dut (.clk(clk), .rst(rst), .instrData(instrData),
    .flowOp(flowOp), .skipTaken(skipTaken), .branchTarget(branchTarget),
    .pcLowWrData(pcLowWrData), .bankPointer(bankPointer), .irqPending(irqPending),
    .fetchAddr(fetchAddr), .fetchStrobe(fetchStrobe), .execInstr(execInstr),
    .execValid(execValid), .cyclePhases(cyclePhases), .cycleStart(cycleStart),
    .pcLowByte(pcLowByte), .irqAck(irqAck), .stackFull(stackFull));
  fsq_prog_mem mem (.clk(clk), .fetchAddr(fetchAddr), .fetchStrobe(fetchStrobe),
    .instrData(instrData));
  // Acknowledge is a one-cycle pulse, so remember that it happened
  always @(posedge clk)
  begin
    if (rst) ackSeen <= 1'b0;
    else if (irqAck === 1'b1) ackSeen <= 1'b1;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic do_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Present one flow op over the WB phase; returns in the new cycle's fetch phase
  task automatic issue(input fsq_pkg::fsq_op_t op, output logic [14:0] prev);
    int n = 0;
    #1;
    while (cyclePhases !== 2'h2 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    prev = fetchAddr;
    @(posedge clk) flowOp <= op;
    @(posedge clk) flowOp <= fsq_pkg::FSQ_OP_SEQ;
    #1;
  endtask
  task automatic t_seq();
    do_reset();
    issue(fsq_pkg::FSQ_OP_SEQ, p);
    issue(fsq_pkg::FSQ_OP_SEQ, p);
    chk("seq addr", {1'h0, p + 15'h0001}, {1'h0, fetchAddr});
    chk("strobe", 16'h0001, {15'h0, fetchStrobe});
    chk("phase", 16'h0000, {14'h0, cyclePhases});
    @(posedge clk);
    #1;
    chk("valid", 16'h0001, {15'h0, execValid});
    chk("instr", {1'h1, fetchAddr}, execInstr);
    repeat (3) @(posedge clk);
    #1;
    chk("cycle start", 16'h0001, {15'h0, cycleStart});
    $display("test seq done");
  endtask
  task automatic t_jump();
    @(posedge clk);
    bankPointer <= 2'h2;
    branchTarget <= 13'h1ABC;
    issue(fsq_pkg::FSQ_OP_JUMP, p);
    chk("jump addr", 16'h5ABC, {1'h0, fetchAddr});
    @(posedge clk);
    #1;
    chk("jump dummy", 16'h0000, {15'h0, execValid});
    chk("pcl read", 16'h00BC, {8'h0, pcLowByte});
    issue(fsq_pkg::FSQ_OP_SEQ, p);
    chk("jump refetch", 16'h5ABC, {1'h0, fetchAddr});
    @(posedge clk);
    #1;
    chk("jump valid", 16'h0001, {15'h0, execValid});
    chk("jump instr", 16'hDABC, execInstr);
    $display("test jump done");
  endtask
  task automatic t_skip();
    for (int t = 0; t < 2; t++)
    begin
      @(posedge clk) skipTaken <= t[0];
      issue(fsq_pkg::FSQ_OP_SKIP, p);
      skipTaken <= 1'b0;
      chk("skip addr", {1'h0, p + 15'(1 + t)}, {1'h0, fetchAddr});
      @(posedge clk);
      #1;
      chk("skip valid", {15'h0, ~t[0]}, {15'h0, execValid});
      if (t == 1)
      begin
        issue(fsq_pkg::FSQ_OP_SEQ, q);
        chk("skip refetch", {1'h0, q}, {1'h0, fetchAddr});
      end
    end
    @(posedge clk) pcLowWrData <= 8'hFF;
    issue(fsq_pkg::FSQ_OP_PCLWR, p);
    chk("pcl addr", {1'h0, p[14:8], 8'hFF}, {1'h0, fetchAddr});
    @(posedge clk);
    #1;
    chk("pcl dummy", 16'h0000, {15'h0, execValid});
    issue(fsq_pkg::FSQ_OP_SEQ, p);
    $display("test skip done");
  endtask
  task automatic call_to(input int i, input logic [12:0] tgt);
    @(posedge clk) branchTarget <= tgt;
    issue(fsq_pkg::FSQ_OP_CALL, ret[i]);
    chk("call addr", {3'h0, tgt}, {1'h0, fetchAddr});
    issue(fsq_pkg::FSQ_OP_SEQ, p);
  endtask
  task automatic t_stack();
    do_reset();
    bankPointer <= 2'h0;
    issue(fsq_pkg::FSQ_OP_SEQ, p);
    for (int i = 0; i < 12; i++) call_to(i, 13'(13'h0100 + 16 * i));
    chk("full", 16'h0001, {15'h0, stackFull});
    @(posedge clk) irqPending <= 1'b1;
    issue(fsq_pkg::FSQ_OP_SEQ, p);
    chk("irq held", {1'h0, p + 15'h0001}, {1'h0, fetchAddr});
    call_to(12, 13'h0F00);
    issue(fsq_pkg::FSQ_OP_RET, p);
    chk("ret addr", {1'h0, ret[12] + 15'h0001}, {1'h0, fetchAddr});
    chk("no ack", 16'h0000, {15'h0, ackSeen});
    issue(fsq_pkg::FSQ_OP_SEQ, p);
    issue(fsq_pkg::FSQ_OP_SEQ, q);
    chk("irq addr", {1'h0, `FSQ_IRQ_VECTOR}, {1'h0, fetchAddr});
    repeat (2) @(posedge clk);
    irqPending <= 1'b0;
    #1;
    chk("ack", 16'h0001, {15'h0, ackSeen});
    issue(fsq_pkg::FSQ_OP_SEQ, p);
    issue(fsq_pkg::FSQ_OP_INTERRUPT_RETURN, p);
    chk("interrupt_return addr", {1'h0, q}, {1'h0, fetchAddr});
    for (int i = 11; i >= 0; i--)
    begin
      issue(fsq_pkg::FSQ_OP_SEQ, p);
      issue(fsq_pkg::FSQ_OP_RET, p);
      if (i > 0) chk("unwind", {1'h0, ret[i] + 15'h0001}, {1'h0, fetchAddr});
      else chk("oldest lost", 16'h0001, {15'h0, fetchAddr !== ret[0] + 15'h0001});
    end
    chk("empty", 16'h0000, {15'h0, stackFull});
    $display("test stack done");
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is a few hundred cycles; this limit only catches a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial
  begin
    t_seq();
    t_jump();
    t_skip();
    t_stack();
    results();
  end
endmodule // fetch_sequencer_pc_stack_test

// ===== sim/fsq_prog_mem.sv
`timescale 1ns/1ns
// Program memory seen from the core; word is tied to its address for easy checking
module fsq_prog_mem (
  input  wire logic        clk,
  input  wire logic [14:0] fetchAddr,
  input  wire logic        fetchStrobe,
  output logic      [15:0] instrData
);
  logic lastStb;
  // Word is valid in the strobe cycle and the one after it only
  always_ff @(posedge clk)
  begin
    lastStb <= fetchStrobe;
  end
  // Outside that window the lines carry the inverse so a late sample cannot pass
  assign instrData = (fetchStrobe | lastStb) ? {1'h1, fetchAddr} : ~{1'h1, fetchAddr};
endmodule // fsq_prog_mem
